// ==== bench/led_current_monitor.sv ====
`timescale 1ns/1ps
module led_current_monitor (
  // bank ports, observed only
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_wr_en,
  input wire logic        i_rd_en,
  input wire logic [7:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_rd_hit,
  input wire logic [2:0]  i_output_mode_select,
  input wire logic [1:0]  i_gpio_function,
  input wire logic [2:0]  i_battery_threshold_select,
  input wire logic [4:0]  i_second_led_torch_code,
  input wire logic        i_transmit_mask_input,
  input wire logic        i_battery_low,
  input wire logic [5:0]  o_led1_code,
  input wire logic [13:0] o_led1_current,
  input wire logic [5:0]  o_led2_code,
  input wire logic [13:0] o_led2_current
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic mapped;
  logic assist;
  logic idle;
  assign mapped = i_addr inside {[8'h05:8'h0a]};
  assign assist = i_output_mode_select == 3'h2;
  assign idle = !(i_output_mode_select inside {3'h2, 3'h3});
  read_hit_a: assert property (o_rd_hit |-> $past(i_rd_en && mapped))
    else $error("read hit without a mapped read");
  read_answer_a: assert property (i_rd_en && mapped |=> o_rd_hit)
    else $error("mapped read gave no hit");
  unmapped_read_a: assert property ($past(i_rd_en && !mapped) |->
    o_rdata == 8'h00 && !o_rd_hit) else $error("unmapped read answered");
  led1_scale_a: assert property (o_led1_current == o_led1_code * 14'd187)
    else $error("led1 current off scale");
  led2_scale_a: assert property (o_led2_current == o_led2_code * 14'd187)
    else $error("led2 current off scale");
  flash_cap_a: assert property (o_led1_code <= 6'h3c && o_led2_code <= 6'h3c)
    else $error("code above ceiling");
  torch_cap_a: assert property ($past(assist, 2) && $past(assist) |->
    o_led1_code <= 6'h10) else $error("torch code above ceiling");
  mode_off_a: assert property ($past(idle, 2) && $past(idle) |->
    o_led1_code == 6'h00 && o_led2_code == 6'h00) else $error("idle drive");
endmodule
bind led_current_setting_bank led_current_monitor led_current_monitor_inst (.*);

// ==== bench/led_current_setting_bank_tb_top.sv ====
`timescale 1ns/1ps
module led_current_setting_bank_tb_top;
  logic        i_clk, i_rst, wr, rd, mask, low, o_rd_hit;
  logic [7:0]  addr, wdata, o_rdata;
  logic [2:0]  mode, thr;
  logic [1:0]  gpio;
  logic [4:0]  tor2;
  logic [5:0]  c1, c2, k1, k2, p;
  logic [13:0] a1, a2;
  logic [31:0] r;
  logic [7:0]  q[$];
  integer      mismatches = 0, checks = 0, seed = 32'h659c;
  led_host_model led_host_model_inst (.i_clk(i_clk), .o_wr_en(wr),
    .o_rd_en(rd), .o_addr(addr), .o_wdata(wdata));
  led_current_setting_bank led_current_setting_bank_inst (.i_clk(i_clk),
    .i_rst(i_rst), .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(o_rdata), .o_rd_hit(o_rd_hit),
    .i_output_mode_select(mode), .i_gpio_function(gpio),
    .i_battery_threshold_select(thr), .i_second_led_torch_code(tor2),
    .i_transmit_mask_input(mask), .i_battery_low(low), .o_led1_code(c1),
    .o_led1_current(a1), .o_led2_code(c2), .o_led2_current(a2));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic chk(input string n, input logic [13:0] s, e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [5:0] sat(input logic [5:0] c, m);
    return c > m ? m : c;
  endfunction
  task automatic rdq(input logic [7:0] a, e);
    q.push_back(e);
    led_host_model_inst.rd(a);
  endtask
  // sync plus decode latency is three edges; four leaves margin
  task automatic tgt(input logic [5:0] e1, e2);
    repeat (4) @(posedge i_clk);
    #1;
    chk("led1 code", {8'h00, c1}, {8'h00, e1});
    chk("led2 code", {8'h00, c2}, {8'h00, e2});
    chk("led1 ma", a1, e1 * 14'd187);
    chk("led2 ma", a2, e2 * 14'd187);
    // hand back on an edge so the next stimulus lands on it
    @(posedge i_clk);
  endtask
  always @(posedge i_clk) begin
    #1;
    if (o_rd_hit === 1'b1) begin
      if (q.size() == 0) chk("stray hit", 14'h1, 14'h0);
      else chk("rdata", {6'h00, o_rdata}, {6'h00, q.pop_front()});
    end
  end
  initial begin
    #1000000;
    mismatches++;
    close_out();
  end
  initial begin
    static logic [7:0] ra [6] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a};
    static logic [7:0] rv [6] = '{8'h10, 8'h28, 8'h28, 8'h04, 8'h28, 8'h28};
    logic [7:0] v [6];
    static logic [5:0] fc [6] = '{6'h00, 6'h01, 6'h10, 6'h3c, 6'h3f, 6'h28};
    static logic [4:0] tc [5] = '{5'h00, 5'h04, 5'h10, 5'h11, 5'h1f};
    i_rst = 1'b1;
    {mode, thr, gpio, tor2, mask, low} = '0;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (ra[i]) rdq(ra[i], rv[i]);
    foreach (ra[i]) begin
      r = $random(seed);
      v[i] = r[7:0];
      led_host_model_inst.wr(ra[i], v[i]);
      rdq(ra[i], v[i]);
    end
    led_host_model_inst.rd(8'h0b);
    $display("register test done");
    mode <= 3'h3;
    p = sat(v[1][5:0], 6'h3c);
    foreach (fc[i]) begin
      r = $random(seed);
      k1 = fc[i];
      k2 = fc[5 - i];
      led_host_model_inst.wr(8'h09, {r[7:6], k2});
      led_host_model_inst.wr(8'h06, {r[1:0], k1});
      // the edge that takes the write still shows the old target
      #1;
      chk("led1 early", {8'h00, c1}, {8'h00, p});
      p = sat(k1, 6'h3c);
      tgt(p, sat(k2, 6'h3c));
    end
    $display("flash test done");
    thr <= 3'h1;
    low <= 1'b1;
    tgt(sat(v[0][5:0], 6'h3c), sat(v[0][5:0], 6'h3c));
    thr <= 3'h0;
    tgt(p, sat(k2, 6'h3c));
    thr <= 3'h1;
    gpio <= 2'h2;
    mask <= 1'b1;
    tgt(sat(v[2][5:0], 6'h3c), sat(v[5][5:0], 6'h3c));
    gpio <= 2'h1;
    tgt(sat(v[0][5:0], 6'h3c), sat(v[0][5:0], 6'h3c));
    $display("override test done");
    {mask, low} <= 2'b00;
    mode <= 3'h2;
    foreach (tc[i]) begin
      r = $random(seed);
      tor2 <= r[12:8];
      led_host_model_inst.wr(8'h08, {r[7:5], tc[i]});
      tgt(sat({1'b0, tc[i]}, 6'h10), sat({1'b0, r[12:8]}, 6'h10));
    end
    $display("torch test done");
    for (int m = 0; m < 8; m++) begin
      if (m != 2 && m != 3) begin
        mode <= m[2:0];
        tgt(6'h00, 6'h00);
      end
    end
    $display("mode test done");
    repeat (4) @(posedge i_clk);
    chk("pending reads", 14'(q.size()), 14'h0);
    close_out();
  end
endmodule

// ==== bench/led_host_model.sv ====
`timescale 1ns/1ps
module led_host_model (
  // clock
  input  wire logic       i_clk,
  // register strobes toward the bank
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // idle bus shows inverted values so stale data is never mistaken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr_en <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    o_rd_en <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
  endtask
endmodule

// ==== core/current_code_decoder.sv ====
`timescale 1ns/1ps
module current_code_decoder #(
  parameter logic [5:0] SAT_CODE = led_current_pkg::FLASH_SAT
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // selected code
  input  wire logic [5:0]  i_code,
  // registered target
  output logic      [5:0]  o_code,
  output logic      [13:0] o_current
);

  logic [5:0]  code_q;
  logic [13:0] cur_q;
  logic [5:0]  next_code;
  logic [13:0] next_cur;

  always_comb begin
    next_code = (i_code > SAT_CODE) ? SAT_CODE : i_code;
    // both factors widened first so the product is never cut at eight bits
    next_cur  = 14'(next_code)
                * 14'(led_current_pkg::STEP_TENTH_MA);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      code_q <= 6'h00;
      cur_q  <= 14'h0000;
    end else begin
      code_q <= next_code;
      cur_q  <= next_cur;
    end
  end

  assign o_code    = code_q;
  assign o_current = cur_q;

endmodule

// ==== core/led_current_pkg.sv ====
package led_current_pkg;

  // register offsets on the device register port
  localparam logic [7:0] ADDR_LOW_BATT   = 8'h05;
  localparam logic [7:0] ADDR_LED1_FLASH = 8'h06;
  localparam logic [7:0] ADDR_LED1_MASK  = 8'h07;
  localparam logic [7:0] ADDR_LED1_TORCH = 8'h08;
  localparam logic [7:0] ADDR_LED2_FLASH = 8'h09;
  localparam logic [7:0] ADDR_LED2_MASK  = 8'h0a;
  localparam int         NUM_REGS        = 6;

  // reset values
  localparam logic [7:0] RST_LOW_BATT   = 8'h10;
  localparam logic [7:0] RST_LED1_FLASH = 8'h28;
  localparam logic [7:0] RST_LED1_MASK  = 8'h28;
  localparam logic [7:0] RST_LED1_TORCH = 8'h04;
  localparam logic [7:0] RST_LED2_FLASH = 8'h28;
  localparam logic [7:0] RST_LED2_MASK  = 8'h28;

  // field layout
  localparam int         CODE_W        = 6;
  localparam int         TORCH_W       = 5;
  localparam logic [7:0] FLASH_FIELD_M = 8'h3f;
  localparam logic [7:0] TORCH_FIELD_M = 8'h1f;

  // current scale: one step is 18.7 mA, reported in units of 0.1 mA
  localparam int         CUR_W         = 14;
  localparam logic [7:0] STEP_TENTH_MA = 8'hbb;
  localparam logic [5:0] FLASH_SAT     = 6'h3c;
  localparam logic [5:0] TORCH_SAT     = 6'h10;

  // control codes from neighbouring registers
  localparam logic [2:0] MODE_ASSIST   = 3'h2;
  localparam logic [2:0] MODE_FLASH    = 3'h3;
  localparam logic [1:0] GPIO_TX_MASK  = 2'h2;
  localparam logic [2:0] BATT_DET_OFF  = 3'h0;

endpackage

// ==== core/led_current_setting_bank.sv ====
// How it works
// - register 0x05 bits 5:0 hold low-battery flash code, reset 0x10
// - six-bit code requests code times 18.7 mA, zero code gives zero
// - codes 0x3c and above all request the 1122 mA ceiling
// - register 0x06 bits 5:0 hold first LED flash code, reset 0x28
// - register 0x07 bits 5:0 hold first LED mask code, reset 0x28
// - register 0x08 bits 4:0 hold first LED torch code, reset 0x04
// - torch request never exceeds 299.2 mA; top code gives that maximum
// - register 0x09 bits 5:0 hold second LED flash code, reset 0x28
// - register 0x0a bits 5:0 hold second LED mask code, reset 0x28
// - mask codes apply only with GPIO mask function, mask input, flash
// - low-battery code applies only when detection enabled and battery low
// - mode 010 uses torch codes, mode 011 uses flash codes
`timescale 1ns/1ps
module led_current_setting_bank (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // register port from the serial interface engine
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata,
  output logic             o_rd_hit,
  // settings held in neighbouring registers
  input  wire logic [2:0]  i_output_mode_select,
  input  wire logic [1:0]  i_gpio_function,
  input  wire logic [2:0]  i_battery_threshold_select,
  input  wire logic [4:0]  i_second_led_torch_code,
  // asynchronous pins and comparator
  input  wire logic        i_transmit_mask_input,
  input  wire logic        i_battery_low,
  // current targets to the current sources, 0.1 mA units
  output logic      [5:0]  o_led1_code,
  output logic      [13:0] o_led1_current,
  output logic      [5:0]  o_led2_code,
  output logic      [13:0] o_led2_current
);

  localparam logic [7:0] RST_VAL [led_current_pkg::NUM_REGS] = '{
    led_current_pkg::RST_LOW_BATT,
    led_current_pkg::RST_LED1_FLASH,
    led_current_pkg::RST_LED1_MASK,
    led_current_pkg::RST_LED1_TORCH,
    led_current_pkg::RST_LED2_FLASH,
    led_current_pkg::RST_LED2_MASK
  };
  localparam logic [7:0] ADDR_VAL [led_current_pkg::NUM_REGS] = '{
    led_current_pkg::ADDR_LOW_BATT,
    led_current_pkg::ADDR_LED1_FLASH,
    led_current_pkg::ADDR_LED1_MASK,
    led_current_pkg::ADDR_LED1_TORCH,
    led_current_pkg::ADDR_LED2_FLASH,
    led_current_pkg::ADDR_LED2_MASK
  };

  // register storage, whole bytes kept so reserved bits read back
  logic [7:0] regs      [led_current_pkg::NUM_REGS];
  logic [7:0] next_regs [led_current_pkg::NUM_REGS];
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic       rd_hit;
  logic       next_rd_hit;

  always_comb begin
    for (int i = 0; i < led_current_pkg::NUM_REGS; i++) begin
      next_regs[i] = regs[i];
      if (i_wr_en && i_addr == ADDR_VAL[i]) begin
        next_regs[i] = i_wdata;
      end
    end
  end

  // read data registered one cycle after the strobe; unmapped reads zero
  always_comb begin
    next_rdata  = 8'h00;
    next_rd_hit = 1'b0;
    if (i_rd_en) begin
      for (int i = 0; i < led_current_pkg::NUM_REGS; i++) begin
        if (i_addr == ADDR_VAL[i]) begin
          next_rdata  = regs[i];
          next_rd_hit = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < led_current_pkg::NUM_REGS; i++) begin
        regs[i] <= RST_VAL[i];
      end
      rdata  <= 8'h00;
      rd_hit <= 1'b0;
    end else begin
      for (int i = 0; i < led_current_pkg::NUM_REGS; i++) begin
        regs[i] <= next_regs[i];
      end
      rdata  <= next_rdata;
      rd_hit <= next_rd_hit;
    end
  end

  assign o_rdata  = rdata;
  assign o_rd_hit = rd_hit;

  // two-flop synchronisers for the pin and the comparator
  logic [1:0] mask_sync;
  logic [1:0] batt_sync;
  logic [1:0] next_mask_sync;
  logic [1:0] next_batt_sync;

  always_comb begin
    next_mask_sync = {mask_sync[0], i_transmit_mask_input};
    next_batt_sync = {batt_sync[0], i_battery_low};
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_sync <= 2'h0;
      batt_sync <= 2'h0;
    end else begin
      mask_sync <= next_mask_sync;
      batt_sync <= next_batt_sync;
    end
  end

  // code selection per LED, from stored registers except the LED2 torch code taken from its input, so a write lands
  // in the targets no earlier than the cycle after it completes
  logic       mask_active;
  logic       batt_active;
  logic [5:0] led1_sel;
  logic [5:0] led2_sel;

  always_comb begin
    mask_active = (i_gpio_function == led_current_pkg::GPIO_TX_MASK)
                  && mask_sync[1];
    batt_active = (i_battery_threshold_select != led_current_pkg::BATT_DET_OFF)
                  && batt_sync[1];
    led1_sel = 6'h00;
    led2_sel = 6'h00;
    case (i_output_mode_select)
      led_current_pkg::MODE_FLASH: begin
        // mask wins over low battery: the burst is the shorter, harder limit
        if (mask_active) begin
          led1_sel = regs[2][5:0] & led_current_pkg::FLASH_FIELD_M[5:0];
          led2_sel = regs[5][5:0] & led_current_pkg::FLASH_FIELD_M[5:0];
        end else if (batt_active) begin
          led1_sel = regs[0][5:0] & led_current_pkg::FLASH_FIELD_M[5:0];
          led2_sel = regs[0][5:0] & led_current_pkg::FLASH_FIELD_M[5:0];
        end else begin
          led1_sel = regs[1][5:0] & led_current_pkg::FLASH_FIELD_M[5:0];
          led2_sel = regs[4][5:0] & led_current_pkg::FLASH_FIELD_M[5:0];
        end
      end
      led_current_pkg::MODE_ASSIST: begin
        led1_sel = {1'b0, regs[3][4:0]
                    & led_current_pkg::TORCH_FIELD_M[4:0]};
        led2_sel = {1'b0, i_second_led_torch_code};
      end
      default: begin
        led1_sel = 6'h00;
        led2_sel = 6'h00;
      end
    endcase
  end

  // torch ceiling applies only in assist mode; flash ceiling otherwise
  logic        assist;
  logic [5:0]  d1_code;
  logic [13:0] d1_cur;
  logic [5:0]  t1_code;
  logic [13:0] t1_cur;
  logic [5:0]  d2_code;
  logic [13:0] d2_cur;
  logic [5:0]  t2_code;
  logic [13:0] t2_cur;
  logic        assist_q;
  logic        next_assist;

  assign next_assist = (i_output_mode_select == led_current_pkg::MODE_ASSIST);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      assist_q <= 1'b0;
    end else begin
      assist_q <= next_assist;
    end
  end

  assign assist = assist_q;

  current_code_decoder #(.SAT_CODE(led_current_pkg::FLASH_SAT)) u_led1_flash (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_code    (led1_sel),
    .o_code    (d1_code),
    .o_current (d1_cur)
  );
  current_code_decoder #(.SAT_CODE(led_current_pkg::TORCH_SAT)) u_led1_torch (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_code    (led1_sel),
    .o_code    (t1_code),
    .o_current (t1_cur)
  );
  current_code_decoder #(.SAT_CODE(led_current_pkg::FLASH_SAT)) u_led2_flash (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_code    (led2_sel),
    .o_code    (d2_code),
    .o_current (d2_cur)
  );
  current_code_decoder #(.SAT_CODE(led_current_pkg::TORCH_SAT)) u_led2_torch (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_code    (led2_sel),
    .o_code    (t2_code),
    .o_current (t2_cur)
  );

  // outputs are muxes of flop outputs chosen by a flop: glitch-free data
  assign o_led1_code    = assist ? t1_code : d1_code;
  assign o_led1_current = assist ? t1_cur  : d1_cur;
  assign o_led2_code    = assist ? t2_code : d2_code;
  assign o_led2_current = assist ? t2_cur  : d2_cur;

endmodule
